/* hw/lepsr_pkg.sv */
// Purpose: Shared constants for the lane error and power status block.
// Assumes: Byte-wide management registers reached by an 8-bit register index.
// Notes:   All offsets, reset values and field positions live here.
`default_nettype none
package lepsr_pkg;
  localparam int          CNT_W          = 12;
  localparam int          NUM_LANES      = 3;
  localparam logic [7:0]  OFS_L1_LOW     = 8'h1A;
  localparam logic [7:0]  OFS_L1_HIGH    = 8'h1B;
  localparam logic [7:0]  OFS_L2_LOW     = 8'h1C;
  localparam logic [7:0]  OFS_L2_HIGH    = 8'h1D;
  localparam logic [7:0]  OFS_L3_LOW     = 8'h1E;
  localparam logic [7:0]  OFS_L3_HIGH    = 8'h1F;
  localparam logic [7:0]  OFS_POWER      = 8'h20;
  localparam logic [7:0]  OFS_CONTROL    = 8'h09;
  localparam logic [7:0]  OFS_RATIO      = 8'h21;
  localparam int          BIT_PD_STATUS  = 7;
  localparam int          BIT_SB_STATUS  = 6;
  localparam int          BIT_PD_CONTROL = 3;
  localparam int          BIT_RATIO      = 1;
  localparam int          BIT_SWAP       = 0;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [11:0] CNT_RESET      = 12'h000;
  localparam logic [11:0] CNT_MAX        = 12'hFFF;
  localparam logic [11:0] CNT_ONE        = 12'h001;
  typedef enum logic [1:0] {LEPSR_OFF, LEPSR_DOWN, LEPSR_STANDBY, LEPSR_NORMAL} lepsr_state_t;
endpackage
`default_nettype wire

/* hw/lepsr_lane_counter.sv */
// Purpose: One saturating lane error counter.
// Assumes: Error pulses are synchronous to sys_clk.
// Notes:   Holds at full scale rather than wrapping, so a flood never reads as few errors.
`default_nettype none
module lepsr_lane_counter (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        error_pulse,
  output logic [11:0]      count
);
  // Clear wins; otherwise count up and stop at the top.
  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
      count <= lepsr_pkg::CNT_RESET;
    else if (error_pulse && count != lepsr_pkg::CNT_MAX)
      count <= count + lepsr_pkg::CNT_ONE;
  end
endmodule
`default_nettype wire

/* hw/lepsr_top.sv */
// Purpose: Error counters, power state flags and clock ratio bit of a video retimer.
// Assumes: Management port presents a byte index, write strobe and read strobe.
// Notes:   Read data is registered and appears one cycle after the read strobe.
//
// Summary of operation
// [R1] Lane 1 error count reads as low byte at 1Ah and upper four bits at 1Bh[3:0], reset zero.
// [R2] Lane 2 error count reads as low byte at 1Ch and upper four bits at 1Dh[3:0], reset zero.
// [R3] Lane 3 error count reads as low byte at 1Eh and upper four bits at 1Fh[3:0], reset zero.
// [R4] Bit 7 of 20h is high while powered down and low otherwise.
// [R5] Bit 6 of 20h is high in standby, with bits 5:0 reading zero.
// [R6] A falling hot plug input clears the clock ratio bit by itself.
// [R7] The source must write the clock ratio bit or the high-rate setup may be wrong.
// [R8] The sink must clear its ratio bit on lost source power or hot plug low for 100 ms.
// [R9] The chip enable pin must stay steady until both rails settle.
// [R10] An input lane swap option remaps the receive lanes in reversed order.
// [R11] Configuration comes from the management port or from strap pins.
// [R12] Equalizer is adaptive by default, fixed when the select pin asks for it.
// [R13] Chip enable low is the lowest power state and its rise is a full reset.
// [R14] Power-down also follows a control bit write or hot plug low with chip enable high.
// [R15] Standby is hot plug high without a valid clock on the clock lane.
// [R16] Entry to power-down clears every management register including the ratio bit.
// [R17] Each counter adds one per error in normal operation and saturates at its maximum.
`default_nettype none
module lepsr_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        chip_enable,
  input  wire logic        hot_plug_sink_input,
  input  wire logic        clock_valid,
  input  wire logic        equalizer_select_pin,
  input  wire logic        swap_strap,
  input  wire logic        i2c_present,
  input  wire logic [3:0]  lane_error_in,
  input  wire logic [7:0]  reg_index,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  output logic             hot_plug_source_output,
  output logic             power_down_active,
  output logic             ratio_high,
  output logic             lane_swap,
  output logic             eq_fixed
);
  lepsr_pkg::lepsr_state_t state;
  logic                    ce_prev;
  logic                    hpd_prev;
  logic                    pd_control;
  logic                    swap_control;
  logic                    wipe;
  wire logic [3:0]         lane_err;
  logic [11:0]             cnt [lepsr_pkg::NUM_LANES];
  logic [7:0]              next_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Edge history of chip enable and hot plug. Both reset low, so a chip enable that is
  // already high out of reset reads as one more rise; that only repeats the wipe of reset.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ce_prev  <= 1'b0;
      hpd_prev <= 1'b0;
    end
    else
    begin
      ce_prev  <= chip_enable;
      hpd_prev <= hot_plug_sink_input;
    end
  end

  // Registers wipe while powered down, and on the chip enable rise. [R13] [R16]
  // The wipe is decoded from the registered state, so it starts one edge after entry;
  // the ratio bit therefore clears on the same edge that power_down_active rises.
  assign wipe = rst || state == lepsr_pkg::LEPSR_OFF || state == lepsr_pkg::LEPSR_DOWN
                || (chip_enable && !ce_prev);

  // Power state selection; off outranks power-down outranks standby.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= lepsr_pkg::LEPSR_OFF;
    else if (!chip_enable)
      state <= lepsr_pkg::LEPSR_OFF;                     // [R13]
    else if (pd_control || !hot_plug_sink_input)
      state <= lepsr_pkg::LEPSR_DOWN;                    // [R14]
    else if (!clock_valid)
      state <= lepsr_pkg::LEPSR_STANDBY;                 // [R15]
    else
      state <= lepsr_pkg::LEPSR_NORMAL;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control bits written over the management port. The power-down bit itself is
  // wiped on entry, so the device leaves power-down once the write has taken hold.
  always_ff @(posedge sys_clk)
  begin
    if (wipe && !(reg_write && reg_index == lepsr_pkg::OFS_CONTROL))
    begin
      pd_control   <= 1'b0;                              // [R16]
      swap_control <= 1'b0;
    end
    else if (reg_write && reg_index == lepsr_pkg::OFS_CONTROL)
    begin
      pd_control   <= reg_wdata[lepsr_pkg::BIT_PD_CONTROL]; // [R14]
      swap_control <= reg_wdata[lepsr_pkg::BIT_SWAP];       // [R10] [R11]
    end
  end

  // Clock ratio bit: set by a source write, cleared by hot plug falling or wipe.
  // The clear outranks a write in the same cycle: a ratio written as the cable is
  // pulled belongs to the old link and must not survive it.
  always_ff @(posedge sys_clk)
  begin
    if (wipe || (hpd_prev && !hot_plug_sink_input))
      ratio_high <= 1'b0;                                // [R6] [R16]
    else if (reg_write && reg_index == lepsr_pkg::OFS_RATIO)
      ratio_high <= reg_wdata[lepsr_pkg::BIT_RATIO];     // [R7]
  end

  // Swap from register when management is present, else from the strap. [R11]
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lane_swap <= 1'b0;
      eq_fixed  <= 1'b0;
    end
    else
    begin
      lane_swap <= i2c_present ? swap_control : swap_strap; // [R10] [R11]
      eq_fixed  <= equalizer_select_pin;                    // [R12]
    end
  end

  // Hot plug is repeated to the source and power-down is shown as a pin.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hot_plug_source_output <= 1'b0;
      power_down_active      <= 1'b0;
    end
    else
    begin
      hot_plug_source_output <= hot_plug_sink_input;
      power_down_active      <= state == lepsr_pkg::LEPSR_OFF || state == lepsr_pkg::LEPSR_DOWN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reversed lane order maps lane n to lane 3-n before counting. [R10]
  // Lane 0 is carried through the swap but has no counter in this block.
  genvar b;
  generate
    for (b = 0; b <= lepsr_pkg::NUM_LANES; b++)
    begin : g_swap
      assign lane_err[b] = lane_swap ? lane_error_in[lepsr_pkg::NUM_LANES - b] : lane_error_in[b]; // [R10]
    end
  endgenerate

  // One saturating counter for each of lanes 1 to 3.
  // Errors only count in normal operation; a link that is down or without a clock
  // would otherwise flood the totals with noise.
  genvar g;
  generate
    for (g = 0; g < lepsr_pkg::NUM_LANES; g++)
    begin : g_lane
      lepsr_lane_counter u_cnt (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .clear       (wipe),
        .error_pulse (lane_err[g + 1] && state == lepsr_pkg::LEPSR_NORMAL),
        .count       (cnt[g])
      );                                                 // [R17]
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped indexes read zero.
  // The two halves of a count are not latched together, so a host reads both
  // while the lane is quiet to get a consistent value.
  always_comb
  begin
    next_rdata = lepsr_pkg::RESET_BYTE;
    unique case (reg_index)
      lepsr_pkg::OFS_L1_LOW:  next_rdata = cnt[0][7:0];          // [R1]
      lepsr_pkg::OFS_L1_HIGH: next_rdata = {4'h0, cnt[0][11:8]}; // [R1]
      lepsr_pkg::OFS_L2_LOW:  next_rdata = cnt[1][7:0];          // [R2]
      lepsr_pkg::OFS_L2_HIGH: next_rdata = {4'h0, cnt[1][11:8]}; // [R2]
      lepsr_pkg::OFS_L3_LOW:  next_rdata = cnt[2][7:0];          // [R3]
      lepsr_pkg::OFS_L3_HIGH: next_rdata = {4'h0, cnt[2][11:8]}; // [R3]
      lepsr_pkg::OFS_POWER:
      begin
        next_rdata[lepsr_pkg::BIT_PD_STATUS] = power_down_active;               // [R4]
        next_rdata[lepsr_pkg::BIT_SB_STATUS] = state == lepsr_pkg::LEPSR_STANDBY; // [R5]
      end
      lepsr_pkg::OFS_CONTROL:
      begin
        next_rdata[lepsr_pkg::BIT_PD_CONTROL] = pd_control;
        next_rdata[lepsr_pkg::BIT_SWAP]       = swap_control;
      end
      lepsr_pkg::OFS_RATIO:   next_rdata[lepsr_pkg::BIT_RATIO] = ratio_high;
      default:                next_rdata = lepsr_pkg::RESET_BYTE;
    endcase
  end

  // Registered read answer, one cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata  <= lepsr_pkg::RESET_BYTE;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* tb/lepsr_monitor.sv */
// Purpose: Port checks of the lane error and power status block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every lepsr_top.
`default_nettype none
module lepsr_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       chip_enable,
  input wire logic       hot_plug_sink_input,
  input wire logic       equalizer_select_pin,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       power_down_active,
  input wire logic       ratio_high,
  input wire logic       eq_fixed
);
  timeunit 1ns;
  timeprecision 100ps;
  // Checks share the device clock and sleep while reset is held.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A write to 09h may hold power-down for a few edges, so the quiet window is six.
  a_ratio_unplug: assert property ($fell(hot_plug_sink_input) |=> !ratio_high) else $error("ratio kept");
  a_off_ce_low: assert property (!chip_enable [*2] |=> power_down_active) else $error("not off");
  a_down_unplug: assert property ((chip_enable && !hot_plug_sink_input) [*2] |=> power_down_active)
    else $error("not down");
  a_up_when_quiet: assert property ((chip_enable && hot_plug_sink_input && !reg_write) [*6]
    |-> !power_down_active) else $error("stuck down");
  a_ratio_down_clear: assert property (power_down_active |-> !ratio_high) else $error("ratio in down");
  a_rvalid_timing: assert property (!$past(rst) |-> reg_rvalid == $past(reg_read)) else $error("rvalid");
  a_rdata_holds: assert property (!$past(rst) && !$past(reg_read) |-> $stable(reg_rdata))
    else $error("rdata moved");
  a_eq_copy: assert property (!$past(rst) |-> eq_fixed == $past(equalizer_select_pin)) else $error("eq");
endmodule
////////////////////////////////////////////////////////////////////////
bind lepsr_top lepsr_monitor mon_u (.sys_clk, .rst, .chip_enable, .hot_plug_sink_input, .equalizer_select_pin,
  .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .power_down_active, .ratio_high, .eq_fixed);
`default_nettype wire

/* tb/lepsr_host.sv */
// Purpose: Host and source model on the register port.
// Assumes: Strobes are sampled on the rising clock edge.
// Notes:   Idle index and data are inverted, never left stale.
`default_nettype none
module lepsr_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic [7:0] reg_index = 8'h00,
  output var  logic       reg_write = 1'b0,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_read = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // One-edge write strobe; the source sets the ratio bit this way.
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge sys_clk) #1 reg_index = i;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge sys_clk) #1 reg_write = 1'b0;
    reg_index = ~i;
    reg_wdata = ~v;
  endtask
  // Read data is taken one edge after the strobe, only if flagged valid.
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    @(posedge sys_clk) #1 reg_index = i;
    reg_read = 1'b1;
    @(posedge sys_clk) #1 reg_read = 1'b0;
    reg_index = ~i;
    v = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* tb/lane_error_and_power_status_test.sv */
// Purpose: Self-checking bench for the lane error and power status block.
// Assumes: All register traffic goes through the host model.
// Notes:   Saturation of lane 3 is driven with 4100 pulses, about 8.2k cycles.
`default_nettype none
module lane_error_and_power_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, plug = 1'b1, clkv = 1'b1;
  logic       eqs = 1'b1, strap = 1'b0, i2c = 1'b0, wr, rd, rvalid, pda, ratio, swp, hps, eqf;
  logic [3:0] lerr = 4'h0;
  logic [7:0] idx, wd, rdata, d;
  logic [7:0] rows [8][2] = '{'{8'h1A, 8'h05}, '{8'h1B, 8'h01}, '{8'h1C, 8'h13}, '{8'h1D, 8'h00},
                              '{8'h1E, 8'h03}, '{8'h1F, 8'h00}, '{8'h20, 8'h00}, '{8'h30, 8'h00}};
  int         fails = 0, checks_done = 0, cyc = 0;
  lepsr_top dut_u (.sys_clk, .rst, .chip_enable(ce), .hot_plug_sink_input(plug), .clock_valid(clkv),
    .equalizer_select_pin(eqs), .swap_strap(strap), .i2c_present(i2c), .lane_error_in(lerr), .reg_index(idx),
    .reg_write(wr), .reg_wdata(wd), .reg_read(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .hot_plug_source_output(hps), .power_down_active(pda), .ratio_high(ratio), .lane_swap(swp), .eq_fixed(eqf));
  lepsr_host host_u (.sys_clk, .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_index(idx), .reg_write(wr),
    .reg_wdata(wd), .reg_read(rd));
  ////////////////////////////////////////////////////////////////////////
  // A 4 ns clock, and a ceiling well above the expected run length.
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end
  // Comparison, error pulse train and verdict helpers.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("mismatch at %0t got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic pulse(input int n, input logic [3:0] m);
    repeat (n)
    begin
      @(posedge sys_clk) #1 lerr = m;
      @(posedge sys_clk) #1 lerr = 4'h0;
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values, counts per lane, then power states and saturation.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int i = 8'h1A; i <= 8'h20; i++)
    begin
      host_u.rd(8'(i), d);
      chk(d, 8'h00);
    end
    pulse(3, 4'hE);
    pulse(16, 4'h6);
    pulse(242, 4'h2);
    foreach (rows[i])
    begin
      host_u.rd(rows[i][0], d);
      chk(d, rows[i][1]);
    end
    clkv = 1'b0;
    host_u.rd(8'h20, d);
    chk(d, 8'h40);
    clkv = 1'b1;
    eqs = 1'b0;
    pulse(4100, 4'h8);
    host_u.rd(8'h1E, d);
    chk(d, 8'hFF);
    host_u.rd(8'h1F, d);
    chk(d, 8'h0F);
    chk(eqf, 1'b0);
    host_u.wr(8'h21, 8'h02);
    chk(ratio, 1'b1);
    plug = 1'b0;
    @(posedge sys_clk) #1 chk(ratio, 1'b0);
    chk(hps, 1'b0);
    @(posedge sys_clk) #1 chk(pda, 1'b1);
    host_u.rd(8'h20, d);
    chk(d, 8'h80);
    plug = 1'b1;
    host_u.wr(8'h21, 8'h02);
    ce = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk(pda, 1'b1);
    ce = 1'b1;
    strap = 1'b1;
    host_u.rd(8'h21, d);
    chk(d, 8'h00);
    chk(swp, 1'b1);
    pulse(1, 4'h2);
    host_u.rd(8'h1C, d);
    chk(d, 8'h01);
    i2c = 1'b1;
    @(posedge sys_clk) #1 chk(swp, 1'b0);
    host_u.wr(8'h09, 8'h01);
    @(posedge sys_clk) #1 chk(swp, 1'b1);
    host_u.rd(8'h09, d);
    chk(d, 8'h01);
    host_u.wr(8'h09, 8'h08);
    repeat (2) @(posedge sys_clk);
    #1 chk(pda, 1'b1);
    host_u.rd(8'h09, d);
    chk(d, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
